// file: verilog/sas_pkg.sv
// Package with the timing constants, register map and types of the smoke alarm sequencer.
package sas_pkg;

  // Clock and base tick. The time base ticks every half millisecond.
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_TICK_NS     = 500000;
  localparam int TICK_CYC      = T_TICK_NS / CLK_PERIOD_NS;
  localparam int T_TICK_US     = 500;

  // Documented times in microseconds.
  localparam int T_OSC_STBY_US  = 1670000;
  localparam int T_OSC_ALARM_US = 41500;
  localparam int T_STROBE_US    = 10500;
  localparam int T_LED_STBY_US  = 40000000;
  localparam int T_LED_ALARM_US = 1000000;
  localparam int T_TMP_ON_US    = 500000;
  localparam int T_TMP_OFF_US   = 500000;
  localparam int T_TMP_GAP_US   = 1500000;
  localparam int T_CONT_ON_US   = 166000;
  localparam int T_CONT_OFF_US  = 83000;
  localparam int T_CHIRP_US     = 10500;
  localparam int T_HOLD_LOW_US  = 1000;

  // Timer width in ticks; the longest interval is the standby period.
  localparam int TW = 12;

  // Periods and pulse widths in ticks. Periods round down, least widths round up.
  localparam logic [TW-1:0] OSC_STBY_TK  = TW'(T_OSC_STBY_US / T_TICK_US);
  localparam logic [TW-1:0] OSC_ALARM_TK = TW'(T_OSC_ALARM_US / T_TICK_US);
  localparam logic [TW-1:0] STROBE_TK    = TW'((T_STROBE_US + T_TICK_US - 1) / T_TICK_US);
  localparam logic [TW-1:0] TMP_ON_TK    = TW'(T_TMP_ON_US / T_TICK_US);
  localparam logic [TW-1:0] TMP_OFF_TK   = TW'(T_TMP_OFF_US / T_TICK_US);
  localparam logic [TW-1:0] TMP_GAP_TK   = TW'(T_TMP_GAP_US / T_TICK_US);
  localparam logic [TW-1:0] CONT_ON_TK   = TW'(T_CONT_ON_US / T_TICK_US);
  localparam logic [TW-1:0] CONT_OFF_TK  = TW'(T_CONT_OFF_US / T_TICK_US);
  localparam logic [TW-1:0] CHIRP_TK     = TW'((T_CHIRP_US + T_TICK_US - 1) / T_TICK_US);
  localparam logic [TW-1:0] HOLD_LOW_TK  = TW'((T_HOLD_LOW_US + T_TICK_US - 1) / T_TICK_US);

  // LED intervals as counts of oscillator cycles, rounded to nearest.
  localparam int LW = 6;
  localparam logic [LW-1:0] LED_STBY_CYC  =
    LW'((T_LED_STBY_US + T_OSC_STBY_US / 2) / T_OSC_STBY_US);
  localparam logic [LW-1:0] LED_ALARM_CYC =
    LW'((T_LED_ALARM_US + T_OSC_ALARM_US / 2) / T_OSC_ALARM_US);

  // Pulses in one temporal group.
  localparam logic [1:0] TMP_PULSES = 2'h3;

  // Register map, byte addresses on a 32-bit bus.
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LEDCNT = 4'h8;
  localparam int         CTRL_EXT_OSC_BIT = 0;
  localparam logic       CTRL_RESET = 1'h0;

  // Sequencer states for one oscillator cycle.
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_SMOKE = 3'b001,
    SEQ_LBAT  = 3'b010,
    SEQ_CHIRP = 3'b011,
    SEQ_SKIP  = 3'b100
  } sas_seq_e;

  // Horn pattern states.
  typedef enum logic [1:0] {
    HORN_IDLE = 2'b00,
    HORN_ON   = 2'b01,
    HORN_OFF  = 2'b10
  } sas_horn_e;

  // Status word as software reads it; the first member is the top bit.
  typedef struct packed {
    logic forced_strobe;
    logic ext_osc;
    logic isolate;
    logic strobe;
    logic led;
    logic horn;
    logic lowbat;
    logic alarm;
  } sas_status_s;

endpackage

// file: verilog/sas_tick_div.sv
// Divider that turns the system clock into a one-cycle tick enable.
`timescale 1ns/1ns
`default_nettype none
module sas_tick_div
  import sas_pkg::*;
#(
  parameter int DIV = TICK_CYC
) (
  input  wire logic clock,   // System clock.
  input  wire logic arst_n,  // Asynchronous reset, active low.
  output logic      tick     // One-cycle pulse every DIV clocks.
);

  localparam int CW = $clog2(DIV + 1);

  logic [CW-1:0] cnt_r;

  // Free-running count; the pulse is registered so it is glitch free.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (cnt_r == CW'(DIV - 1)) begin
      cnt_r <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: verilog/sas_top.sv
// Timing sequencer of an ionization smoke alarm with an Avalon-MM register slave.
`timescale 1ns/1ns
`default_nettype none
module sas_top
  import sas_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC
) (
  input  wire logic        clock,              // System clock, 100 MHz.
  input  wire logic        arst_n,             // Asynchronous reset, active low.
  input  wire logic        smoke_cmp_pin,      // Smoke comparator, high on smoke.
  input  wire logic        lowbat_cmp_pin,     // Battery comparator, high when low.
  input  wire logic        tone_sel_pin,       // Pattern select, high or pulled up.
  input  wire logic        timing_cap_pin,     // Timing capacitor pin level.
  input  wire logic [3:0]  avs_address,        // Byte address.
  input  wire logic        avs_read,           // Read request.
  input  wire logic        avs_write,          // Write request.
  input  wire logic [31:0] avs_writedata,      // Write data.
  input  wire logic [3:0]  avs_byteenable,     // Byte lanes.
  output logic [31:0]      avs_readdata,       // Read data.
  output logic             avs_waitrequest,    // Stall, low when answered.
  output logic             power_strobe,       // Detector power strobe.
  output logic             led_drive,          // LED low-side driver on.
  output logic             horn_drive,         // Horn driver on.
  output logic             hysteresis_en,      // Raise smoke reference.
  output logic             sens_isolate        // Open sensitivity_node switch.
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and time base.

  localparam int NPIN = 4;

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_m1;
  logic [NPIN-1:0] pin_s;
  logic            tick;

  assign pin_raw = {timing_cap_pin, tone_sel_pin, lowbat_cmp_pin, smoke_cmp_pin};

  // Two flops per pin; only the second stage is read by the logic.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          pin_m1[gi] <= 1'b0;
          pin_s[gi]  <= 1'b0;
        end else begin
          pin_m1[gi] <= pin_raw[gi];
          pin_s[gi]  <= pin_m1[gi];
        end
      end
    end
  endgenerate

  logic smoke_s;
  logic lowbat_s;
  logic tone_s;
  logic cap_s;

  assign smoke_s  = pin_s[0];
  assign lowbat_s = pin_s[1];
  assign tone_s   = pin_s[2];
  assign cap_s    = pin_s[3];

  sas_tick_div #(
    .DIV (TICK_DIV)
  ) u_tick (
    .clock  (clock),
    .arst_n (arst_n),
    .tick   (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State declarations.

  logic          ctrl_ext_r;
  logic          smoke_r;
  logic          lowbat_r;
  logic [TW-1:0] osc_cnt_r;
  logic [TW-1:0] low_cnt_r;
  logic          cap_d_r;
  logic [TW-1:0] strb_cnt_r;
  logic [LW-1:0] led_div_r;
  logic          chirp_due_r;
  sas_seq_e      seq_r;
  sas_horn_e     horn_r;
  logic          pat_tmp_r;
  logic [1:0]    pulse_r;
  logic [TW-1:0] hcnt_r;

  logic          alarm;
  logic          forced;
  logic          osc_edge;
  logic          strobe_end;
  logic          horn_start;
  logic [TW-1:0] osc_len;
  logic [LW-1:0] led_len;

  assign alarm = smoke_r;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator model.

  // The period follows the alarm state; >= lets a shortened period take
  // effect at once instead of waiting out a long standby count.
  assign osc_len = alarm ? OSC_ALARM_TK : OSC_STBY_TK;

  // Internal oscillator counts ticks; external mode uses pin rising edges.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_r <= '0;
      cap_d_r   <= 1'b0;
    end else begin
      cap_d_r <= cap_s;
      if (tick) begin
        if (osc_cnt_r >= osc_len - 1'b1) begin
          osc_cnt_r <= '0;
        end else begin
          osc_cnt_r <= osc_cnt_r + 1'b1;
        end
      end
    end
  end

  // A tester's square wave replaces the internal period; the strobe width
  // is still timed internally so the analog side gets its settling time.
  assign osc_edge = ctrl_ext_r ? (cap_s && !cap_d_r)
                               : (tick && osc_cnt_r >= osc_len - 1'b1);

  // Count how long the capacitor pin has been low; a 4 kHz wave never
  // stays low across two ticks, so only a real hold forces the strobe.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_r <= '0;
    end else if (cap_s) begin
      low_cnt_r <= '0;
    end else if (tick && low_cnt_r < HOLD_LOW_TK) begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  assign forced = (low_cnt_r >= HOLD_LOW_TK);

  ////////////////////////////////////////////////////////////////////////////
  // Per-cycle sequencer.

  assign led_len    = alarm ? LED_ALARM_CYC : LED_STBY_CYC;
  assign strobe_end = tick && (strb_cnt_r == STROBE_TK - 1'b1);

  // Each oscillator cycle opens one strobe whose purpose is picked here.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seq_r       <= SEQ_IDLE;
      strb_cnt_r  <= '0;
      led_div_r   <= '0;
      chirp_due_r <= 1'b0;
    end else begin
      case (seq_r)
        SEQ_IDLE: begin
          strb_cnt_r <= '0;
          if (osc_edge) begin
            if (led_div_r >= led_len - 1'b1) begin
              led_div_r   <= '0;
              seq_r       <= SEQ_LBAT;
              chirp_due_r <= 1'b1;
            end else begin
              led_div_r <= led_div_r + 1'b1;
              if (chirp_due_r && lowbat_r && !alarm) begin
                seq_r       <= SEQ_CHIRP;
                chirp_due_r <= 1'b0;
              end else if (horn_r == HORN_IDLE) begin
                seq_r       <= SEQ_SMOKE;
                chirp_due_r <= 1'b0;
              end else begin
                seq_r       <= SEQ_SKIP;
                chirp_due_r <= 1'b0;
              end
            end
          end
        end
        SEQ_SMOKE, SEQ_LBAT, SEQ_CHIRP, SEQ_SKIP: begin
          if (strobe_end) begin
            seq_r      <= SEQ_IDLE;
            strb_cnt_r <= '0;
          end else if (tick) begin
            strb_cnt_r <= strb_cnt_r + 1'b1;
          end
        end
        default: begin
          seq_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Smoke is latched at the end of a smoke strobe only, never during the
  // battery test, the chirp or a running horn cycle.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      smoke_r <= 1'b0;
    end else if (seq_r == SEQ_SMOKE && strobe_end) begin
      smoke_r <= smoke_s;
    end
  end

  // Battery status is taken as the LED pulse ends, so it reads under load.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lowbat_r <= 1'b0;
    end else if (seq_r == SEQ_LBAT && strobe_end) begin
      lowbat_r <= lowbat_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Horn pattern generator.

  assign horn_start = (seq_r == SEQ_SMOKE) && strobe_end && smoke_s;

  // One group per smoke check: three temporal pulses or one tone period.
  // Returning to idle between groups is what lets smoke be checked again.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      horn_r    <= HORN_IDLE;
      pat_tmp_r <= 1'b1;
      pulse_r   <= '0;
      hcnt_r    <= '0;
    end else begin
      case (horn_r)
        HORN_IDLE: begin
          hcnt_r  <= '0;
          pulse_r <= '0;
          if (horn_start) begin
            pat_tmp_r <= tone_s;
            horn_r    <= HORN_ON;
          end
        end
        HORN_ON: begin
          if (tick) begin
            if (hcnt_r >= (pat_tmp_r ? TMP_ON_TK : CONT_ON_TK) - 1'b1) begin
              hcnt_r <= '0;
              horn_r <= HORN_OFF;
            end else begin
              hcnt_r <= hcnt_r + 1'b1;
            end
          end
        end
        HORN_OFF: begin
          if (tick) begin
            if (!pat_tmp_r) begin
              if (hcnt_r >= CONT_OFF_TK - 1'b1) begin
                hcnt_r <= '0;
                horn_r <= HORN_IDLE;
              end else begin
                hcnt_r <= hcnt_r + 1'b1;
              end
            end else if (pulse_r == TMP_PULSES - 1'b1) begin
              if (hcnt_r >= TMP_GAP_TK - 1'b1) begin
                hcnt_r <= '0;
                horn_r <= HORN_IDLE;
              end else begin
                hcnt_r <= hcnt_r + 1'b1;
              end
            end else if (hcnt_r >= TMP_OFF_TK - 1'b1) begin
              hcnt_r  <= '0;
              pulse_r <= pulse_r + 1'b1;
              horn_r  <= HORN_ON;
            end else begin
              hcnt_r <= hcnt_r + 1'b1;
            end
          end
        end
        default: begin
          horn_r <= HORN_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.

  // Outputs are one clock behind the state so every pin comes from a flop.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_strobe  <= 1'b0;
      led_drive     <= 1'b0;
      horn_drive    <= 1'b0;
      hysteresis_en <= 1'b0;
      sens_isolate  <= 1'b0;
    end else begin
      power_strobe  <= (seq_r != SEQ_IDLE) || forced;
      led_drive     <= (seq_r == SEQ_LBAT);
      horn_drive    <= (horn_r == HORN_ON) || (seq_r == SEQ_CHIRP);
      hysteresis_en <= smoke_r;
      sens_isolate  <= (seq_r == SEQ_LBAT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave.

  sas_status_s status;
  logic [31:0] rd_mux;
  logic        take;

  assign status = '{
    forced_strobe: forced,
    ext_osc:       ctrl_ext_r,
    isolate:       sens_isolate,
    strobe:        power_strobe,
    led:           led_drive,
    horn:          horn_drive,
    lowbat:        lowbat_r,
    alarm:         smoke_r
  };

  // Unmapped addresses read as zero and ignore writes.
  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      REG_CTRL:   rd_mux = {31'h0, ctrl_ext_r};
      REG_STATUS: rd_mux = {24'h0, status};
      REG_LEDCNT: rd_mux = {{(32 - LW){1'b0}}, led_div_r};
      default:    rd_mux = 32'h0;
    endcase
  end

  // The request is taken at the edge where waitrequest is seen low.
  assign take = (avs_read || avs_write) && !avs_waitrequest;

  // Waitrequest idles high, drops for one cycle after a request appears.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : 32'h0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Control register; only the low byte lane carries a writable bit.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ext_r <= CTRL_RESET;
    end else if (take && avs_write && avs_address == REG_CTRL && avs_byteenable[0]) begin
      ctrl_ext_r <= avs_writedata[CTRL_EXT_OSC_BIT];
    end
  end

endmodule
`default_nettype wire

// file: tb/sas_chk.sv
// Checker of pin timing and bus handshake for the smoke alarm sequencer.
`timescale 1ns/1ns
`default_nettype none
module sas_chk
  import sas_pkg::*;
#(
  parameter int TICK_DIV = 10
) (
  input wire logic clock,           // System clock.
  input wire logic arst_n,          // Reset, active low.
  input wire logic timing_cap_pin,  // Cap pin level.
  input wire logic avs_read,        // Read request.
  input wire logic avs_write,       // Write request.
  input wire logic avs_waitrequest, // Stall.
  input wire logic power_strobe,    // Detector power.
  input wire logic led_drive,       // LED driver.
  input wire logic horn_drive,      // Horn driver.
  input wire logic hysteresis_en,   // Alarm hysteresis.
  input wire logic sens_isolate     // Sensitivity switch open.
);
  localparam int HB = 4 * TICK_DIV + 8;
  logic [19:0] low_r, str_r, hon_r, led_r;

  // Run lengths in clocks; the strobe run restarts when the cap pin is low, where it is forced.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      low_r <= '0;
      str_r <= '0;
      hon_r <= '0;
      led_r <= '0;
    end else begin
      low_r <= timing_cap_pin ? '0 : low_r + 20'h1;
      str_r <= (power_strobe && timing_cap_pin) ? str_r + 20'h1 : '0;
      hon_r <= horn_drive ? hon_r + 20'h1 : '0;
      led_r <= led_drive ? led_r + 20'h1 : '0;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (!$past(arst_n) |-> avs_waitrequest && !power_strobe
    && !led_drive && !horn_drive && !hysteresis_en && !sens_isolate)
    else $error("Outputs not idle after reset.");
  a_bus_answer: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest) // Handshake.
    else $error("Bus request not answered in two edges.");
  a_bus_single: assert property (!avs_waitrequest |=> avs_waitrequest) // Handshake.
    else $error("Waitrequest low for more than one cycle.");
  a_isolate_led: assert property (sens_isolate == led_drive)
    else $error("Sensitivity switch not open with battery test.");
  a_led_strobe: assert property (led_drive |-> power_strobe)
    else $error("LED pulse without detector power.");
  a_led_width: assert property (led_r <= 20'(22 * TICK_DIV))
    else $error("LED pulse too long.");
  a_strobe_width: assert property (str_r <= 20'(22 * TICK_DIV + 8))
    else $error("Power strobe too long.");
  a_forced_strobe: assert property (low_r >= 20'(4 * TICK_DIV) |-> power_strobe)
    else $error("Cap pin held low without strobe.");
  a_chirp_width: assert property ($fell(horn_drive) && !hysteresis_en |->
    hon_r >= 20'(20 * TICK_DIV) && hon_r <= 20'(22 * TICK_DIV))
    else $error("Battery chirp width wrong.");
  a_no_chirp_alarm: assert property ($fell(horn_drive) && hysteresis_en |->
    hon_r > 20'(300 * TICK_DIV)) else $error("Short horn pulse during alarm.");
  a_alarm_horn: assert property ($rose(hysteresis_en) |-> ##[0:HB] horn_drive)
    else $error("Alarm latched without horn.");
endmodule

bind sas_top sas_chk #(.TICK_DIV(TICK_DIV)) u_sas_chk (
  .clock(clock), .arst_n(arst_n), .timing_cap_pin(timing_cap_pin),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .power_strobe(power_strobe), .led_drive(led_drive), .horn_drive(horn_drive),
  .hysteresis_en(hysteresis_en), .sens_isolate(sens_isolate)
);
`default_nettype wire

// file: tb/sas_far.sv
// Far-side model: comparators, tester square wave on the cap pin, and horn and LED monitor.
`timescale 1ns/1ns
`default_nettype none
module sas_far #(
  parameter int HALF = 120
) (
  input  wire logic clock,          // System clock.
  input  wire logic arst_n,         // Reset, active low.
  input  wire logic osc_run,        // Run the square wave.
  input  wire logic hold_low,       // Hold the cap pin low.
  input  wire logic smoke_lvl,      // Chamber sees smoke.
  input  wire logic lowbat_lvl,     // Battery is low.
  input  wire logic tone_lvl,       // Pattern strap level.
  input  wire logic power_strobe,   // Detector power.
  input  wire logic led_drive,      // LED load.
  input  wire logic horn_drive,     // Horn driver.
  output logic      smoke_cmp_pin,  // Smoke comparator.
  output logic      lowbat_cmp_pin, // Battery comparator.
  output logic      tone_sel_pin,   // Pattern select.
  output logic      timing_cap_pin  // Cap pin.
);
  int   runs[$];
  int   hcnt, lcnt, ocnt, led_w, horn_w, osc_n;
  logic hprev, lprev;

  // Tester clock on the cap pin; it stands high while stopped.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timing_cap_pin <= 1'b1;
      ocnt <= 0;
      osc_n <= 0;
    end else if (hold_low) begin
      timing_cap_pin <= 1'b0;
      ocnt <= 0;
    end else if (!osc_run || ocnt == HALF - 1) begin
      timing_cap_pin <= !osc_run || !timing_cap_pin;
      ocnt <= 0;
      osc_n <= osc_n + int'(osc_run && !timing_cap_pin);
    end else begin
      ocnt <= ocnt + 1;
    end
  end

  // Unpowered comparators show the wrong level, so a late or early latch is caught.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      smoke_cmp_pin <= 1'b0;
      lowbat_cmp_pin <= 1'b0;
      tone_sel_pin <= 1'b1;
    end else begin
      smoke_cmp_pin <= power_strobe ? smoke_lvl : !smoke_lvl;
      lowbat_cmp_pin <= led_drive ? lowbat_lvl : !lowbat_lvl;
      tone_sel_pin <= tone_lvl;
    end
  end

  // Horn run lengths and last LED and horn widths, in clocks.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      hprev <= 1'b0;
      lprev <= 1'b0;
      hcnt <= 0;
      lcnt <= 0;
    end else begin
      hprev <= horn_drive;
      lprev <= led_drive;
      hcnt <= (horn_drive == hprev) ? hcnt + 1 : 1;
      lcnt <= led_drive ? lcnt + 1 : 0;
      if (horn_drive != hprev) runs.push_back(hcnt);
      if (hprev && !horn_drive) horn_w <= hcnt;
      if (lprev && !led_drive) led_w <= lcnt;
    end
  end
endmodule
`default_nettype wire

// file: tb/smoke_alarm_sequencer_bench.sv
// Self-checking bench of the smoke alarm sequencer with its far-side model.
`timescale 1ns/1ns
`default_nettype none
module smoke_alarm_sequencer_bench;
  import sas_pkg::*;
  localparam int TD  = 4;       // Short tick keeps a temporal group inside the run.
  localparam int STR = 21 * TD; // Strobe, LED and chirp width in clocks.
  logic        clock, arst_n, rd, wr, osc_run, hold_low, smoke, lowbat, tone;
  logic        smoke_pin, lowbat_pin, tone_pin, cap_pin, waitreq, strobe, led, horn, hyst, iso;
  logic [3:0]  addr, be;
  logic [31:0] wd, rdata, q, rnd;
  int          fails, n_checks, i, n0, need;
  int          exp_runs[$];

  // Clock of 10 ns period.
  initial clock = 1'b0;
  always #5 clock = ~clock;

  sas_top #(.TICK_DIV(TD)) u_sas_top (
    .clock(clock), .arst_n(arst_n), .smoke_cmp_pin(smoke_pin), .lowbat_cmp_pin(lowbat_pin),
    .tone_sel_pin(tone_pin), .timing_cap_pin(cap_pin), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .power_strobe(strobe), .led_drive(led), .horn_drive(horn),
    .hysteresis_en(hyst), .sens_isolate(iso)
  );
  sas_far #(.HALF(30 * TD)) u_sas_far (
    .clock(clock), .arst_n(arst_n), .osc_run(osc_run), .hold_low(hold_low),
    .smoke_lvl(smoke), .lowbat_lvl(lowbat), .tone_lvl(tone), .power_strobe(strobe),
    .led_drive(led), .horn_drive(horn), .smoke_cmp_pin(smoke_pin),
    .lowbat_cmp_pin(lowbat_pin), .tone_sel_pin(tone_pin), .timing_cap_pin(cap_pin)
  );

  ////////////////////////////////////////////////////////////
  // Mismatch line and counting.
  task report(input logic [31:0] got, input logic [31:0] exp);
    fails++;
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) report(got, exp);
  endtask
  // Widths move by the partial first tick, so they get a window.
  task rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) report(got, lo);
  endtask
  task stop_test;
    $display("fails=%0d n_checks=%0d", fails, n_checks);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One bus word; the request stands until waitrequest is sampled low.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (waitreq === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 50) begin
      report(32'(k), 32'h2);
      stop_test;
    end
  endtask
  // Bounded wait for LED (0), horn (1), alarm (2) level or for need horn runs (3).
  task wt(input int s, input logic v);
    int k;
    for (k = 0; k < 60000; k++) begin
      @(posedge clock);
      if (s == 0 && led === v || s == 1 && horn === v || s == 2 && hyst === v) break;
      if (s == 3 && u_sas_far.runs.size() >= need) break;
    end
    // One more edge lets the far side post the widths it took at the change.
    @(posedge clock);
    if (k == 60000) begin
      report(32'(s), 32'(v));
      stop_test;
    end
  endtask

  // Main sequence.
  initial begin
    {arst_n, rd, wr, osc_run, hold_low, smoke, lowbat} = '0;
    tone = 1'b1;
    addr = 4'h0;
    wd = 32'h0;
    be = 4'hf;
    fails = 0;
    n_checks = 0;
    rnd = $urandom(75);
    rnd = $urandom;
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    chk(32'({waitreq, strobe, led, horn, hyst, iso}), 32'h20);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h47, 32'h0);
    bus(1'b0, 4'hc, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
    be <= 4'h0;
    bus(1'b1, REG_CTRL, 32'h1);
    bus(1'b0, REG_CTRL, 32'h0);
    chk(q[0], 32'h0);
    be <= 4'hf;
    bus(1'b1, REG_CTRL, {rnd[31:1], 1'b1});
    bus(1'b0, REG_CTRL, 32'h0);
    chk(q[0], 32'h1);
    hold_low <= 1'b1;
    repeat (6 * TD) @(posedge clock);
    chk(strobe, 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[7:5], 32'h6);
    hold_low <= 1'b0;
    repeat (30 * TD) @(posedge clock);
    $display("test registers and forced strobe done");
    osc_run <= 1'b1;
    wt(0, 1'b1);
    n0 = u_sas_far.osc_n;
    wt(0, 1'b0);
    rng(u_sas_far.led_w, STR - TD - 3, STR + TD + 3);
    wt(0, 1'b1);
    chk(32'(u_sas_far.osc_n - n0), 32'd24);
    lowbat <= 1'b1;
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[1], 32'h0);
    wt(0, 1'b0);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[1], 32'h1);
    wt(1, 1'b1);
    wt(1, 1'b0);
    rng(u_sas_far.horn_w, STR - TD - 3, STR + TD + 3);
    $display("test standby cycles done");
    tone <= 1'b0;
    smoke <= 1'b1;
    wt(2, 1'b1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(q[0], 32'h1);
    wt(1, 1'b0);
    wt(1, 1'b1);
    @(posedge clock);
    u_sas_far.runs.delete();
    need = 10;
    wt(3, 1'b1);
    for (i = 0; i < 10; i += 2) begin
      rng(u_sas_far.runs[i], 332 * TD - TD - 3, 332 * TD + TD + 3);
      rng(u_sas_far.runs[i + 1], 166 * TD - TD - 3, 260 * TD);
    end
    $display("test continuous tone done");
    lowbat <= 1'b0;
    wt(0, 1'b1);
    wt(0, 1'b0);
    smoke <= 1'b0;
    wt(2, 1'b0);
    tone <= 1'b1;
    smoke <= 1'b1;
    wt(1, 1'b0);
    wt(1, 1'b1);
    @(posedge clock);
    u_sas_far.runs.delete();
    exp_runs = '{1000, 1000, 1000, 1000, 1000, 3000};
    need = 6;
    wt(3, 1'b1);
    for (i = 0; i < 5; i++) begin
      rng(u_sas_far.runs[i], exp_runs[i] * TD - TD - 3, exp_runs[i] * TD + TD + 3);
    end
    rng(u_sas_far.runs[5], exp_runs[5] * TD - TD - 3, 3100 * TD);
    $display("test temporal pattern done");
    bus(1'b1, REG_CTRL, 32'h0);
    osc_run <= 1'b0;
    wt(0, 1'b0);
    wt(0, 1'b1);
    n0 = int'($time / 10);
    wt(0, 1'b0);
    wt(0, 1'b1);
    rng(int'($time / 10) - n0, 24 * 83 * TD - 3, 24 * 83 * TD + 3);
    $display("test alarm oscillator done");
    stop_test;
  end
endmodule
`default_nettype wire
